// ### rtl/port_zero_pkg.sv
// constants, types and helpers shared by the port zero pin control design
// What this block does
// - pull enable bit 0 disconnects the line's pull transistor, 1 connects it
// - pull direction bit 0 selects pulldown, 1 selects pullup
// - power-down drive enable 1 keeps the line's driver on in power down
// - 8-bit demultiplexed bus uses only the low half; high half stays general I/O
// - during reset every line is an input held high by internal pullup
// - line high at reset picks default option, line low picks the alternative
// - at reset end sampled bus configuration loads the first bus config register
// - at reset end high byte sample goes to read-only startup register
// - multiplexed read drives 16-bit address, then turns port to input
// - word over 8-bit bus takes two data phases, low byte then high byte
// - multiplexed writes drive data after the address phase
// - demultiplexed modes carry only data, read in or driven out
// - with external bus on, bus controller sets direction and output latch
// - alternate output path feeds the latch; pin input returns on alternate path
// - with external bus off, last written direction register rules again
package port_zero_pkg;

	localparam int LINES = 16;
	localparam int HALF  = 8;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_PULL_SEL_LO = 16'hFE60;
	localparam logic [15:0] IDX_PULL_SEL_HI = 16'hFE62;
	localparam logic [15:0] IDX_PULL_EN_LO  = 16'hFE64;
	localparam logic [15:0] IDX_PULL_EN_HI  = 16'hFE66;
	localparam logic [15:0] IDX_PD_LO       = 16'hFE68;
	localparam logic [15:0] IDX_PD_HI       = 16'hFE6A;
	localparam logic [15:0] IDX_OUT_LO      = 16'hFE80;
	localparam logic [15:0] IDX_OUT_HI      = 16'hFE82;
	localparam logic [15:0] IDX_DIR_LO      = 16'hFE84;
	localparam logic [15:0] IDX_DIR_HI      = 16'hFE86;
	localparam logic [15:0] IDX_PIN_IN      = 16'hFE88;
	localparam logic [15:0] IDX_BUS_CFG     = 16'hFE8A;
	localparam logic [15:0] IDX_STARTUP     = 16'hFE8C;

	localparam logic [7:0] RST_PULL_SEL = 8'hFF;
	localparam logic [7:0] RST_PULL_EN  = 8'hFF;
	localparam logic [7:0] RST_PD       = 8'h00;
	localparam logic [7:0] RST_OUT      = 8'h00;
	localparam logic [7:0] RST_DIR      = 8'h00;
	localparam logic [7:0] RST_CFG      = 8'h00;

	// first bus config register fields
	localparam int CFG_EXT_EN_BIT = 0;
	localparam int CFG_MODE_LSB   = 1;

	// data phase length
	localparam int CLK_PERIOD_NS = 40;
	localparam int DATA_PHASE_NS = 120;
	localparam int DATA_CYCLES   = (DATA_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		MODE_DEMUX8  = 2'b00,
		MODE_MUX8    = 2'b01,
		MODE_DEMUX16 = 2'b10,
		MODE_MUX16   = 2'b11
	} bus_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_LOW  = 2'b11,
		ST_HIGH = 2'b10
	} seq_state_type;

	typedef struct packed {
		logic        we;
		logic        word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} ext_req_type;

	typedef struct packed {
		logic        load;
		logic [15:0] drive;
		logic [15:0] data;
	} alt_out_type;

	function automatic logic [7:0] wr_byte(logic [7:0] q, logic [7:0] d, logic en);
		wr_byte = en ? d : q;
	endfunction

	function automatic logic is_bus8(bus_mode_type m);
		is_bus8 = (m == MODE_DEMUX8) || (m == MODE_MUX8);
	endfunction

endpackage

// ### rtl/bus_phase_sequencer.sv
// external access phase sequencer driving the alternate output path
`timescale 1ns/1ps
module bus_phase_sequencer
	import port_zero_pkg::*;
#(
	parameter int PHASE_CYCLES = DATA_CYCLES
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         req_valid,
	input  wire ext_req_type  req,
	output logic              req_ready,
	input  wire bus_mode_type mode,
	input  wire logic [15:0]  pin_in,
	output alt_out_type       alt,
	output logic              rsp_valid,
	output logic [15:0]       rsp_data
);

	initial begin
		// below three a read samples before released lines reach the sync flops
		if (PHASE_CYCLES < 3 || PHASE_CYCLES > 255) begin
			$error("PHASE_CYCLES out of range");
		end
	end

	seq_state_type state_r;
	seq_state_type state_nxt;
	ext_req_type   req_r;
	logic [7:0]    cnt_r;
	logic          phase_end;
	logic          turn;
	logic          bus8;
	logic          mux;

	assign bus8      = is_bus8(mode);
	assign mux       = (mode == MODE_MUX8) || (mode == MODE_MUX16);
	assign req_ready = (state_r == ST_IDLE);
	// multiplexed read: one extra cycle so the address has left the sync flops
	assign turn      = mux && !req_r.we && (state_r == ST_LOW);
	assign phase_end = (cnt_r == (turn ? 8'(PHASE_CYCLES) : 8'(PHASE_CYCLES - 1)));

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: if (req_valid) state_nxt = mux ? ST_ADDR : ST_LOW;
			ST_ADDR: state_nxt = ST_LOW;
			ST_LOW:  if (phase_end) state_nxt = (bus8 && req_r.word) ? ST_HIGH : ST_IDLE;
			ST_HIGH: if (phase_end) state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || state_r != state_nxt) begin
			cnt_r <= 8'h00;
		end else if (state_r != ST_IDLE) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			req_r <= '0;
		end else if (req_valid && req_ready) begin
			req_r <= req;
		end
	end

	// alternate output path: address first, then data or high impedance
	always_comb begin
		alt = '0;
		unique case (state_r)
			ST_IDLE: alt = '0;
			ST_ADDR: begin
				alt.load  = 1'b1;
				alt.drive = 16'hFFFF;
				alt.data  = req_r.addr;
			end
			ST_LOW, ST_HIGH: begin
				if (req_r.we) begin
					alt.load  = 1'b1;
					alt.drive = bus8 ? 16'h00FF : 16'hFFFF;
					if (!bus8) begin
						alt.data = req_r.wdata;
					end else if (state_r == ST_LOW) begin
						alt.data = {8'h00, req_r.wdata[7:0]};
					end else begin
						alt.data = {8'h00, req_r.wdata[15:8]};
					end
				end
			end
		endcase
	end

	// read sample taken on the last cycle of each data phase
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rsp_data <= 16'h0000;
		end else if (phase_end && state_r == ST_LOW) begin
			rsp_data <= bus8 ? {rsp_data[15:8], pin_in[7:0]} : pin_in;
		end else if (phase_end && state_r == ST_HIGH) begin
			rsp_data <= {pin_in[7:0], rsp_data[7:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
		end else begin
			rsp_valid <= phase_end && state_r != ST_IDLE && state_nxt == ST_IDLE;
		end
	end

endmodule

// ### rtl/port_zero_pin_control.sv
// port zero pin control: registers, startup capture and bus takeover
`timescale 1ns/1ps
module port_zero_pin_control
	import port_zero_pkg::*;
#(
	parameter int ADR_W        = 18,
	parameter int PHASE_CYCLES = DATA_CYCLES
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [ADR_W-1:2] wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	input  wire logic             wb_we_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	output logic                  wb_ack_o,
	input  wire logic             powerdown_mode,
	input  wire logic             ext_req_valid,
	input  wire ext_req_type      ext_req,
	output logic                  ext_req_ready,
	output logic                  ext_rsp_valid,
	output logic      [15:0]      ext_rsp_data,
	input  wire logic [15:0]      pin_i,
	output logic      [15:0]      pin_o,
	output logic      [15:0]      pin_oe_n,
	output logic      [15:0]      pull_en,
	output logic      [15:0]      pull_up
);

	initial begin
		if (ADR_W < 18 || ADR_W > 32) begin
			$error("ADR_W must lie between 18 and 32");
		end
	end

	logic [15:0]  pin_s1_r;
	logic [15:0]  pin_s2_r;
	logic [15:0]  strap_r;
	logic         rst_d_r;
	logic [7:0]   pull_sel_lo_r;
	logic [7:0]   pull_sel_hi_r;
	logic [7:0]   pull_en_lo_r;
	logic [7:0]   pull_en_hi_r;
	logic [7:0]   pd_lo_r;
	logic [7:0]   pd_hi_r;
	logic [15:0]  out_r;
	logic [15:0]  out_nxt;
	logic [7:0]   dir_lo_r;
	logic [7:0]   dir_hi_r;
	logic [7:0]   bus_cfg_r;
	logic [7:0]   startup_r;
	logic         ack_r;
	logic [31:0]  dat_r;
	logic [31:0]  dat_nxt;
	logic         acc;
	logic         wr;
	logic [15:0]  idx;
	logic         ext_en;
	bus_mode_type mode;
	logic [15:0]  own_mask;
	logic [15:0]  dir_all;
	logic [15:0]  drive_nxt;
	logic [15:0]  pd_keep;
	alt_out_type  alt;

	// pins come from outside the clock domain
	always_ff @(posedge ref_clk) begin
		pin_s1_r <= pin_i;
		pin_s2_r <= pin_s1_r;
	end

	// strap capture: follows the pins all through reset, frozen after release
	always_ff @(posedge ref_clk) begin
		rst_d_r <= rst;
		if (rst) begin
			strap_r <= pin_s2_r;
		end
	end

	assign acc = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr  = acc && wb_we_i;
	assign idx = wb_adr_i[17:2];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// each half is its own register, so a half write never touches the other
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pull_sel_lo_r <= RST_PULL_SEL;
			pull_sel_hi_r <= RST_PULL_SEL;
		end else if (wr && idx == IDX_PULL_SEL_LO) begin
			pull_sel_lo_r <= wr_byte(pull_sel_lo_r, wb_dat_i[7:0], wb_sel_i[0]);
		end else if (wr && idx == IDX_PULL_SEL_HI) begin
			pull_sel_hi_r <= wr_byte(pull_sel_hi_r, wb_dat_i[7:0], wb_sel_i[0]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pull_en_lo_r <= RST_PULL_EN;
			pull_en_hi_r <= RST_PULL_EN;
		end else if (wr && idx == IDX_PULL_EN_LO) begin
			pull_en_lo_r <= wr_byte(pull_en_lo_r, wb_dat_i[7:0], wb_sel_i[0]);
		end else if (wr && idx == IDX_PULL_EN_HI) begin
			pull_en_hi_r <= wr_byte(pull_en_hi_r, wb_dat_i[7:0], wb_sel_i[0]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pd_lo_r <= RST_PD;
			pd_hi_r <= RST_PD;
		end else if (wr && idx == IDX_PD_LO) begin
			pd_lo_r <= wr_byte(pd_lo_r, wb_dat_i[7:0], wb_sel_i[0]);
		end else if (wr && idx == IDX_PD_HI) begin
			pd_hi_r <= wr_byte(pd_hi_r, wb_dat_i[7:0], wb_sel_i[0]);
		end
	end

	// direction is untouched by the bus controller, so it returns as last written
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dir_lo_r <= RST_DIR;
			dir_hi_r <= RST_DIR;
		end else if (wr && idx == IDX_DIR_LO) begin
			dir_lo_r <= wr_byte(dir_lo_r, wb_dat_i[7:0], wb_sel_i[0]);
		end else if (wr && idx == IDX_DIR_HI) begin
			dir_hi_r <= wr_byte(dir_hi_r, wb_dat_i[7:0], wb_sel_i[0]);
		end
	end

	// bus config: loaded from the strap low byte at release, writable later
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bus_cfg_r <= RST_CFG;
		end else if (rst_d_r) begin
			bus_cfg_r <= strap_r[7:0];
		end else if (wr && idx == IDX_BUS_CFG) begin
			bus_cfg_r <= wr_byte(bus_cfg_r, wb_dat_i[7:0], wb_sel_i[0]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			startup_r <= RST_CFG;
		end else if (rst_d_r) begin
			startup_r <= strap_r[15:8];
		end
	end

	assign ext_en = bus_cfg_r[CFG_EXT_EN_BIT];
	assign mode   = bus_mode_type'(bus_cfg_r[CFG_MODE_LSB +: 2]);

	// lines that the bus controller owns
	always_comb begin
		if (!ext_en) begin
			own_mask = 16'h0000;
		end else if (mode == MODE_DEMUX8) begin
			own_mask = 16'h00FF;
		end else begin
			own_mask = 16'hFFFF;
		end
	end

	bus_phase_sequencer #(
		.PHASE_CYCLES (PHASE_CYCLES)
	) u_seq (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.req_valid (ext_req_valid && ext_en),
		.req       (ext_req),
		.req_ready (ext_req_ready),
		.mode      (mode),
		.pin_in    (pin_s2_r),
		.alt       (alt),
		.rsp_valid (ext_rsp_valid),
		.rsp_data  (ext_rsp_data)
	);

	// output latch: alternate path wins on owned lines; software writes there
	// while the bus is on give an undefined mix and are not guarded
	always_comb begin
		out_nxt = out_r;
		if (wr && idx == IDX_OUT_LO) begin
			out_nxt[7:0] = wr_byte(out_r[7:0], wb_dat_i[7:0], wb_sel_i[0]);
		end
		if (wr && idx == IDX_OUT_HI) begin
			out_nxt[15:8] = wr_byte(out_r[15:8], wb_dat_i[7:0], wb_sel_i[0]);
		end
		if (alt.load) begin
			out_nxt = (out_nxt & ~own_mask) | (alt.data & own_mask);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			out_r <= {RST_OUT, RST_OUT};
		end else begin
			out_r <= out_nxt;
		end
	end

	assign pin_o = out_r;

	assign dir_all = {dir_hi_r, dir_lo_r};
	assign pd_keep = powerdown_mode ? {pd_hi_r, pd_lo_r} : 16'hFFFF;

	// direction: bus controller on owned lines, direction register elsewhere
	always_comb begin
		drive_nxt = (alt.drive & own_mask) | (dir_all & ~own_mask);
		drive_nxt = drive_nxt & pd_keep;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_oe_n <= 16'hFFFF;
		end else begin
			pin_oe_n <= ~drive_nxt;
		end
	end

	// pulls only act on lines that are not driven
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pull_en <= 16'hFFFF;
			pull_up <= 16'hFFFF;
		end else begin
			pull_en <= {pull_en_hi_r, pull_en_lo_r} & ~drive_nxt;
			pull_up <= {pull_sel_hi_r, pull_sel_lo_r};
		end
	end

	// read mux; unmapped indices answer zero
	always_comb begin
		dat_nxt = 32'h0000_0000;
		unique case (idx)
			IDX_PULL_SEL_LO: dat_nxt[7:0] = pull_sel_lo_r;
			IDX_PULL_SEL_HI: dat_nxt[7:0] = pull_sel_hi_r;
			IDX_PULL_EN_LO:  dat_nxt[7:0] = pull_en_lo_r;
			IDX_PULL_EN_HI:  dat_nxt[7:0] = pull_en_hi_r;
			IDX_PD_LO:       dat_nxt[7:0] = pd_lo_r;
			IDX_PD_HI:       dat_nxt[7:0] = pd_hi_r;
			IDX_OUT_LO:      dat_nxt[7:0] = out_r[7:0];
			IDX_OUT_HI:      dat_nxt[7:0] = out_r[15:8];
			IDX_DIR_LO:      dat_nxt[7:0] = dir_lo_r;
			IDX_DIR_HI:      dat_nxt[7:0] = dir_hi_r;
			IDX_PIN_IN:      dat_nxt[15:0] = pin_s2_r;
			IDX_BUS_CFG:     dat_nxt[7:0] = bus_cfg_r;
			IDX_STARTUP:     dat_nxt[7:0] = startup_r;
			default:         dat_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dat_r <= 32'h0000_0000;
		end else if (acc && !wb_we_i) begin
			dat_r <= dat_nxt;
		end
	end

endmodule

// ### dv/ext_memory_model.sv
// far-side model: strap pulldowns during reset, memory read data otherwise
`timescale 1ns/1ps
module ext_memory_model #(
	parameter logic [15:0] STRAP = 16'hA507,
	parameter logic [15:0] RD    = 16'hC3E1
) (
	input  wire logic        rst,
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe_n,
	output logic      [15:0] pin_i
);
	// a driven line shows the device; a released one shows the far side
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			pin_i[i] = !pin_oe_n[i] ? pin_o[i] : (rst ? STRAP[i] : RD[i]);
		end
	end
endmodule

// ### dv/port_zero_asserts.sv
// concurrent checks on the port zero pin control ports
`timescale 1ns/1ps
module port_zero_asserts (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic        powerdown_mode,
	input wire logic        ext_req_valid,
	input wire logic        ext_req_ready,
	input wire logic        ext_rsp_valid,
	input wire logic [15:0] pin_o,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_en,
	input wire logic [15:0] pull_up
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	property p_rst_lines;
		$fell(rst) |-> pin_oe_n == 16'hFFFF && pull_en == 16'hFFFF && pull_up == 16'hFFFF;
	endproperty
	a_rst_lines: assert property (p_rst_lines) else $error("lines not input pulled up in reset");
	property p_rst_out;
		$fell(rst) |-> pin_o == 16'h0000 && !wb_ack_o && !ext_rsp_valid && ext_req_ready;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs wrong at reset end");
	property p_ack_one;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_pull_mask;
		(pull_en & ~pin_oe_n) == 16'h0000;
	endproperty
	a_pull_mask: assert property (p_pull_mask) else $error("pull on a driven line");
	property p_rsp_pulse;
		ext_rsp_valid |=> !ext_rsp_valid;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
	property p_rsp_bound;
		ext_req_valid && ext_req_ready ##1 !ext_req_ready |-> ##[0:12] ext_rsp_valid;
	endproperty
	a_rsp_bound: assert property (p_rsp_bound) else $error("access never completed");
	c_wb_ack: cover property (wb_ack_o && wb_cyc_i);
	c_ext_rsp: cover property (ext_rsp_valid);
	c_pd: cover property (powerdown_mode && pin_oe_n != 16'hFFFF);
endmodule

bind port_zero_pin_control port_zero_asserts port_zero_asserts_inst (
	.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .powerdown_mode(powerdown_mode), .ext_req_valid(ext_req_valid),
	.ext_req_ready(ext_req_ready), .ext_rsp_valid(ext_rsp_valid), .pin_o(pin_o),
	.pin_oe_n(pin_oe_n), .pull_en(pull_en), .pull_up(pull_up));

// ### dv/testbench.sv
// testbench: register access, startup capture and external bus phases
`timescale 1ns/1ps
module testbench;
	import port_zero_pkg::*;
	logic        ref_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, powerdown_mode;
	logic        ext_req_valid, ext_req_ready, ext_rsp_valid;
	logic [17:2] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0]  wb_sel_i;
	logic [15:0] ext_rsp_data, pin_i, pin_o, pin_oe_n, pull_en, pull_up;
	ext_req_type ext_req;
	logic [15:0] seen_q[$];
	logic [15:0] idx_j;
	int          bad_count, checks_done;

	port_zero_pin_control #(.PHASE_CYCLES(3)) port_zero_pin_control_inst (
		.ref_clk(ref_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .powerdown_mode(powerdown_mode),
		.ext_req_valid(ext_req_valid), .ext_req(ext_req), .ext_req_ready(ext_req_ready),
		.ext_rsp_valid(ext_rsp_valid), .ext_rsp_data(ext_rsp_data), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull_en(pull_en), .pull_up(pull_up));
	ext_memory_model ext_memory_model_inst (.rst(rst), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pin_i(pin_i));

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wb(input logic we, input logic [15:0] idx, input logic [31:0] d);
		wb_adr_i <= idx;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1) @(posedge ref_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic reg_chk(input logic [15:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, 32'h0);
		check($sformatf("reg %h", idx), rd, exp);
	endtask

	// logs each new 16-bit pin_o value while the port drives its low lines, until the response
	task automatic ext(input logic we, input logic word, input logic [15:0] a, input logic [15:0] d);
		int   n;
		logic drv;
		seen_q.delete();
		drv = 1'b0;
		ext_req <= '{we, word, a, d};
		ext_req_valid <= 1'b1;
		@(posedge ref_clk);
		ext_req_valid <= 1'b0;
		for (n = 0; n < 40 && ext_rsp_valid !== 1'b1; n++) begin
			@(posedge ref_clk);
			if (pin_oe_n[7:0] == 8'h00 && (!drv || pin_o != seen_q[$])) seen_q.push_back(pin_o);
			drv = (pin_oe_n[7:0] == 8'h00);
		end
	endtask

	task automatic final_report();
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end

	initial begin
		rst = 1'b1;
		{wb_we_i, wb_cyc_i, wb_stb_i, powerdown_mode, ext_req_valid} = 5'h00;
		wb_adr_i = 16'h0000;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		ext_req = '0;
		repeat (16) @(posedge ref_clk);
		check("oe_n rst", pin_oe_n, 16'hFFFF);
		check("pull rst", {pull_en, pull_up}, 32'hFFFFFFFF);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reg_chk(IDX_BUS_CFG, 32'h07);
		reg_chk(IDX_STARTUP, 32'hA5);
		for (int j = 0; j < 10; j++) begin
			idx_j = j < 6 ? 16'hFE60 + 16'(2 * j) : 16'hFE80 + 16'(2 * (j - 6));
			reg_chk(idx_j, j < 4 ? 32'hFF : 32'h0);
		end
		reg_chk(16'hFE70, 32'h0);
		wb(1'b1, IDX_STARTUP, 32'h0);
		reg_chk(IDX_STARTUP, 32'hA5);
		wb(1'b1, IDX_PD_LO, 32'hFFFFFFFF);
		reg_chk(IDX_PD_LO, 32'hFF);
		ext(1'b0, 1'b1, 16'h1234, 16'h0);
		check("mux16 rd", {seen_q.size(), seen_q[0], ext_rsp_data}, {32'd1, 32'h1234C3E1});
		ext(1'b1, 1'b1, 16'h1234, 16'hBEEF);
		check("mux16 wr", {seen_q.size(), seen_q[0], seen_q[1]}, {32'd2, 32'h1234BEEF});
		wb(1'b1, IDX_BUS_CFG, 32'h05);
		ext(1'b0, 1'b1, 16'h1234, 16'h0);
		check("demux16 rd", {seen_q.size(), ext_rsp_data}, {32'd0, 16'hC3E1});
		ext(1'b1, 1'b1, 16'h1234, 16'hBEEF);
		check("demux16 wr", {seen_q.size(), seen_q[0]}, {32'd1, 16'hBEEF});
		wb(1'b1, IDX_BUS_CFG, 32'h01);
		wb(1'b1, IDX_DIR_HI, 32'hFF);
		wb(1'b1, IDX_OUT_HI, 32'h3C);
		ext(1'b1, 1'b1, 16'h1234, 16'hBEEF);
		check("demux8 wr", {seen_q.size(), seen_q[0], seen_q[1]}, {32'd2, 32'h3CEF3CBE});
		check("demux8 hi", {pin_oe_n[15:8], pin_o[15:8]}, 16'h003C);
		wb(1'b1, IDX_BUS_CFG, 32'h03);
		ext(1'b1, 1'b1, 16'h1234, 16'hBEEF);
		check("mux8 wr", {seen_q[0], seen_q[1][7:0], seen_q[2][7:0]}, 32'h1234EFBE);
		ext(1'b0, 1'b1, 16'h1234, 16'h0);
		check("mux8 rd", ext_rsp_data, 16'hE1E1);
		wb(1'b1, IDX_DIR_LO, 32'h0F);
		wb(1'b1, IDX_BUS_CFG, 32'h00);
		repeat (2) @(posedge ref_clk);
		check("dir back", pin_oe_n, 16'h00F0);
		reg_chk(IDX_PIN_IN, 32'h12E4);
		ext(1'b0, 1'b1, 16'h1234, 16'h0);
		check("refused", ext_rsp_valid, 1'b0);
		wb(1'b1, IDX_PULL_SEL_LO, 32'h30);
		repeat (2) @(posedge ref_clk);
		check("pulls", {pull_en, pull_up}, 32'h00F0FF30);
		wb(1'b1, IDX_PULL_EN_LO, 32'h00);
		repeat (2) @(posedge ref_clk);
		check("pull off", pull_en, 16'h0000);
		wb(1'b1, IDX_PD_LO, 32'h05);
		powerdown_mode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("pd drive", pin_oe_n, 16'hFFFA);
		powerdown_mode <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("pd exit", pin_oe_n, 16'h00F0);
		final_report();
	end
endmodule
